// ===== common/tmc_pkg.sv
// package: register map, field positions and codes of the thermal monitor config block
package tmc_pkg;
   // register offsets (byte-wide registers, index on the 8-bit pointer)
   localparam logic [7:0] ADDR_FMT_CFG = 8'h7c;
   localparam logic [7:0] ADDR_PIN_CFG = 8'h7d;
   localparam logic [7:0] ADDR_TEST_A = 8'h7e;
   localparam logic [7:0] ADDR_TEST_B = 8'h7f;
   localparam logic [7:0] ADDR_LOCK_CTRL = 8'h80;
   localparam logic [7:0] ADDR_LIMIT_R1 = 8'h81;
   localparam logic [7:0] ADDR_LIMIT_LOC = 8'h82;
   localparam logic [7:0] ADDR_LIMIT_R2 = 8'h83;
   localparam logic [7:0] ADDR_STATUS = 8'h84;
   localparam int ADDR_W = 10;

   // reset values
   localparam logic [7:0] FMT_CFG_RST = 8'h00;
   localparam logic [7:0] PIN_CFG_RST = 8'h00;
   localparam logic [7:0] TEST_RST = 8'h00;
   localparam logic [7:0] LIMIT_RST = 8'h00;

   // writable masks, reserved bits read zero
   localparam logic [7:0] FMT_CFG_WMASK = 8'hef;
   localparam logic [7:0] PIN_CFG_WMASK = 8'h4f;

   // field positions, format/channel register
   localparam int FMT_TWOS_BIT = 0;
   localparam int FMT_OFFS_BIT = 1;
   localparam int FMT_GPDIR_BIT = 2;
   localparam int FMT_GPPOL_BIT = 3;
   localparam int FMT_EN_R1_BIT = 5;
   localparam int FMT_EN_LOC_BIT = 6;
   localparam int FMT_EN_R2_BIT = 7;
   // field positions, pin/fan register
   localparam int PIN_FUNC_LSB = 0;
   localparam int PIN_OFF_BIT = 2;
   localparam int PIN_FANMAX_BIT = 3;
   localparam int PIN_BYP_BIT = 6;

   // multi-function pin codes
   localparam logic [1:0] MPF_FAN_TACH_INPUT_4 = 2'h0;
   localparam logic [1:0] MPF_OVERTEMP = 2'h1;
   localparam logic [1:0] MPF_ALERT = 2'h2;
   localparam logic [1:0] MPF_GPIO = 2'h3;

   // limit codes that disable a channel: -64 in offset-64, -128 in twos complement
   localparam logic [7:0] LIMIT_OFF_OFS64 = 8'h00;
   localparam logic [7:0] LIMIT_OFF_TWOS = 8'h80;
   localparam logic [7:0] OFS64_BIAS = 8'h40;

   // fan response modes
   localparam logic FAN_FULL = 1'b0;
   localparam logic FAN_MAX_PROG = 1'b1;
endpackage

// ===== core/tmc_config_regs.sv
// thermal monitor configuration registers with Avalon-MM slave
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tmc_config_regs
   import tmc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   // temperatures from the converter, same clock
   input wire logic [7:0] temp_remote_a,
   input wire logic [7:0] temp_local,
   input wire logic [7:0] temp_remote_b,
   // pins from outside
   input wire logic overtemp_pin_in,
   input wire logic multi_pin_in,
   input wire logic gp_out_level,
   input wire logic alert_req,
   // overtemp pin, open drain
   output logic overtemp_pin_out,
   output logic overtemp_pin_oe,
   // multi-function pin
   output logic multi_pin_out,
   output logic multi_pin_oe,
   output logic fan_tach_input_4,
   output logic gp_in_level,
   output logic overtemp_timer_in,
   // fan and analog control
   output logic fans_full_speed,
   output logic fans_max_prog,
   output logic temp_format_select,
   output logic offset_range_select,
   output logic core_volt_atten_bypass
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [7:0] fmt_cfg;
      logic [7:0] pin_cfg;
      logic [7:0] test_a;
      logic [7:0] test_b;
      logic lock;
      logic [7:0] lim_r1;
      logic [7:0] lim_loc;
      logic [7:0] lim_r2;
      logic [1:0] ot_sync;
      logic [1:0] mp_sync;
      logic ack;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic ot_out;
      logic ot_oe;
      logic mp_out;
      logic mp_oe;
      logic tach;
      logic gp_in;
      logic timer_in;
      logic full;
      logic maxp;
      logic fmt;
      logic ofs;
      logic byp;
   } tmc_state_type;

   tmc_state_type s_q;
   tmc_state_type s_d;

   logic over_r1;
   logic over_loc;
   logic over_r2;
   logic dis_r1;
   logic dis_loc;
   logic dis_r2;

   // byte-wide view of a word address; low two bits must be zero
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a == {off, 2'b00});
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                        input logic [7:0] msk);
      merge = (old & ~msk) | (nw & msk);
   endfunction

   // any register of the decoded window, read-only ones included
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] >= ADDR_FMT_CFG)
         && (a[ADDR_W-1:2] <= ADDR_STATUS);
   endfunction

   // ************************************************************
   // channel compare
   // ************************************************************
   tmc_temp_cmp u_cmp_r1 (.twos_mode(s_q.fmt_cfg[FMT_TWOS_BIT]), .temp(temp_remote_a),
      .limit(s_q.lim_r1), .over(over_r1), .disabled(dis_r1));
   tmc_temp_cmp u_cmp_loc (.twos_mode(s_q.fmt_cfg[FMT_TWOS_BIT]), .temp(temp_local),
      .limit(s_q.lim_loc), .over(over_loc), .disabled(dis_loc));
   tmc_temp_cmp u_cmp_r2 (.twos_mode(s_q.fmt_cfg[FMT_TWOS_BIT]), .temp(temp_remote_b),
      .limit(s_q.lim_r2), .over(over_r2), .disabled(dis_r2));

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      logic wr;
      logic rd;
      logic cfg_ok;
      logic ot_hot;
      logic ot_drive;
      logic [1:0] mpf;
      logic gp_oen;
      logic [7:0] wb;
      wr = 1'b0;
      rd = 1'b0;
      cfg_ok = 1'b0;
      ot_hot = 1'b0;
      ot_drive = 1'b0;
      mpf = 2'h0;
      gp_oen = 1'b0;
      wb = 8'h00;
      s_d = s_q;

      // pin synchronisers
      s_d.ot_sync = {s_q.ot_sync[0], overtemp_pin_in};
      s_d.mp_sync = {s_q.mp_sync[0], multi_pin_in};

      // one wait cycle; writes land on the answer edge
      wr = avs_write && s_q.ack;
      rd = avs_read && !s_q.ack;
      s_d.ack = (avs_write || avs_read) && !s_q.ack;
      wb = avs_writedata[7:0];
      cfg_ok = !s_q.lock && avs_byteenable[0];
      s_d.resp = 2'h0;
      if (avs_write && !s_q.ack && !mapped(avs_address))
         s_d.resp = 2'h3;

      if (wr)
      begin
         if (hit(avs_address, ADDR_FMT_CFG))
         begin
            if (cfg_ok)
               s_d.fmt_cfg = merge(s_q.fmt_cfg, wb, FMT_CFG_WMASK);
         end
         else if (hit(avs_address, ADDR_PIN_CFG))
         begin
            if (cfg_ok)
               s_d.pin_cfg = merge(s_q.pin_cfg, wb, PIN_CFG_WMASK);
         end
         else if (hit(avs_address, ADDR_LOCK_CTRL))
         begin
            if (avs_byteenable[0] && wb[0])
               s_d.lock = 1'b1;
         end
         else if (hit(avs_address, ADDR_LIMIT_R1) && avs_byteenable[0])
            s_d.lim_r1 = wb;
         else if (hit(avs_address, ADDR_LIMIT_LOC) && avs_byteenable[0])
            s_d.lim_loc = wb;
         else if (hit(avs_address, ADDR_LIMIT_R2) && avs_byteenable[0])
            s_d.lim_r2 = wb;
      end

      if (rd)
      begin
         s_d.rdata = 32'h0000_0000;
         if (hit(avs_address, ADDR_FMT_CFG))
            s_d.rdata[7:0] = s_q.fmt_cfg & FMT_CFG_WMASK;
         else if (hit(avs_address, ADDR_PIN_CFG))
            s_d.rdata[7:0] = s_q.pin_cfg & PIN_CFG_WMASK;
         else if (hit(avs_address, ADDR_TEST_A))
            s_d.rdata[7:0] = s_q.test_a;
         else if (hit(avs_address, ADDR_TEST_B))
            s_d.rdata[7:0] = s_q.test_b;
         else if (hit(avs_address, ADDR_LOCK_CTRL))
            s_d.rdata[7:0] = {7'h00, s_q.lock};
         else if (hit(avs_address, ADDR_LIMIT_R1))
            s_d.rdata[7:0] = s_q.lim_r1;
         else if (hit(avs_address, ADDR_LIMIT_LOC))
            s_d.rdata[7:0] = s_q.lim_loc;
         else if (hit(avs_address, ADDR_LIMIT_R2))
            s_d.rdata[7:0] = s_q.lim_r2;
         else if (hit(avs_address, ADDR_STATUS))
            s_d.rdata[7:0] = {2'h0, dis_r2, dis_loc, dis_r1, over_r2, over_loc, over_r1};
         else
            s_d.resp = 2'h3;
      end

      // overtemp drive per channel enable
      ot_hot = (s_q.fmt_cfg[FMT_EN_R1_BIT] && over_r1)
         || (s_q.fmt_cfg[FMT_EN_LOC_BIT] && over_loc)
         || (s_q.fmt_cfg[FMT_EN_R2_BIT] && over_r2);
      ot_hot = ot_hot && !s_q.pin_cfg[PIN_OFF_BIT];
      ot_drive = ot_hot;
      s_d.ot_out = 1'b0;
      s_d.ot_oe = ot_drive;

      // multi-function pin
      mpf = s_q.pin_cfg[PIN_FUNC_LSB +: 2];
      s_d.tach = 1'b0;
      s_d.gp_in = 1'b0;
      s_d.timer_in = 1'b0;
      s_d.mp_out = 1'b0;
      s_d.mp_oe = 1'b0;
      case (mpf)
         MPF_FAN_TACH_INPUT_4:
            s_d.tach = s_q.mp_sync[1];
         MPF_OVERTEMP:
         begin
            s_d.mp_oe = ot_hot;
            s_d.timer_in = !s_q.mp_sync[1];
         end
         MPF_ALERT:
            s_d.mp_oe = alert_req;
         MPF_GPIO:
         begin
            gp_oen = s_q.fmt_cfg[FMT_GPDIR_BIT];
            if (gp_oen)
            begin
               s_d.mp_out = s_q.fmt_cfg[FMT_GPPOL_BIT] ? gp_out_level : !gp_out_level;
               s_d.mp_oe = 1'b1;
            end
            else
               s_d.gp_in = s_q.mp_sync[1];
         end
         default:
            s_d.tach = 1'b0;
      endcase
      if (mpf != MPF_OVERTEMP)
         s_d.timer_in = !s_q.ot_sync[1] && !ot_drive;

      // fan response while over limit
      s_d.full = ot_hot && (s_q.pin_cfg[PIN_FANMAX_BIT] == FAN_FULL);
      s_d.maxp = ot_hot && (s_q.pin_cfg[PIN_FANMAX_BIT] == FAN_MAX_PROG);

      // format and scale controls
      s_d.fmt = s_q.fmt_cfg[FMT_TWOS_BIT];
      s_d.ofs = s_q.fmt_cfg[FMT_OFFS_BIT];
      s_d.byp = s_q.pin_cfg[PIN_BYP_BIT];
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_q <= '0;
         s_q.fmt_cfg <= FMT_CFG_RST;
         s_q.pin_cfg <= PIN_CFG_RST;
         s_q.test_a <= TEST_RST;
         s_q.test_b <= TEST_RST;
         s_q.lim_r1 <= LIMIT_RST;
         s_q.lim_loc <= LIMIT_RST;
         s_q.lim_r2 <= LIMIT_RST;
      end
      else
         s_q <= s_d;
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = !s_q.ack;
   assign avs_response = s_q.resp;
   assign overtemp_pin_out = s_q.ot_out;
   assign overtemp_pin_oe = s_q.ot_oe;
   assign multi_pin_out = s_q.mp_out;
   assign multi_pin_oe = s_q.mp_oe;
   assign fan_tach_input_4 = s_q.tach;
   assign gp_in_level = s_q.gp_in;
   assign overtemp_timer_in = s_q.timer_in;
   assign fans_full_speed = s_q.full;
   assign fans_max_prog = s_q.maxp;
   assign temp_format_select = s_q.fmt;
   assign offset_range_select = s_q.ofs;
   assign core_volt_atten_bypass = s_q.byp;
endmodule

// ===== core/tmc_temp_cmp.sv
// one temperature channel: format-aware limit compare and disable detect
`timescale 1ns/1ps
module tmc_temp_cmp
   import tmc_pkg::*;
(
   // format
   input wire logic twos_mode,
   // operands
   input wire logic [7:0] temp,
   input wire logic [7:0] limit,
   // results
   output logic over,
   output logic disabled
);
   logic signed [8:0] t_s;
   logic signed [8:0] l_s;

   always_comb
   begin
      // bring both codes to a signed value
      if (twos_mode)
      begin
         t_s = {temp[7], temp};
         l_s = {limit[7], limit};
      end
      else
      begin
         t_s = $signed({1'b0, temp}) - $signed({1'b0, OFS64_BIAS});
         l_s = $signed({1'b0, limit}) - $signed({1'b0, OFS64_BIAS});
      end
      disabled = twos_mode ? (limit == LIMIT_OFF_TWOS) : (limit == LIMIT_OFF_OFS64);
      over = !disabled && (t_s > l_s);
   end
endmodule

// ===== tb/thermal_monitor_config_regs_tb_top.sv
// testbench: register rows, pin function, overtemp response and lock
`timescale 1ns/1ps
module thermal_monitor_config_regs_tb_top
   import tmc_pkg::*;
();
   // ****************
   // stimulus and checks
   // ****************
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] adr;
   logic rd_s, wr_s, ot_out, ot_oe, mp_out, mp_oe, tach, gp_in, tmr, full, maxp;
   logic fmt, ofs, byp;
   logic [31:0] wd, rdat;
   logic [3:0] be;
   logic [1:0] rsp, rr;
   logic wq;
   logic [7:0] rq;
   logic [7:0] t_ra = 8'h00;
   logic mp_drv = 1'b0;
   logic gp_lvl = 1'b0;
   logic ot_ext = 1'b1;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   // rows never write the maker test registers
   logic [23:0] rows [7] = '{24'h7cffef, 24'h7dff4f, 24'h82a5a5, 24'h820000, 24'h815555,
      24'h7c0000, 24'h7d0000};
   logic [19:0] ot [14] = '{20'h81500, 20'h7c206, 20'h7d085, 20'h7d0c0, 20'h7d006,
      20'h81000, 20'h7c216, 20'h81800, 20'h81506, 20'h7c010, 20'h82f00, 20'h7c416,
      20'h7c810, 20'h83f06};
   always #25 mclk = ~mclk;
   tmc_host_model H (.mclk(mclk), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wq), .avs_response(rsp));
   tmc_config_regs DUT (.mclk(mclk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd_s),
      .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wq), .avs_response(rsp), .temp_remote_a(t_ra), .temp_local(8'h00),
      .temp_remote_b(8'h00), .overtemp_pin_in(ot_oe ? ot_out : ot_ext),
      .multi_pin_in(mp_oe ? mp_out : mp_drv), .gp_out_level(gp_lvl), .alert_req(1'b0),
      .overtemp_pin_out(ot_out), .overtemp_pin_oe(ot_oe), .multi_pin_out(mp_out),
      .multi_pin_oe(mp_oe), .fan_tach_input_4(tach), .gp_in_level(gp_in),
      .overtemp_timer_in(tmr), .fans_full_speed(full), .fans_max_prog(maxp),
      .temp_format_select(fmt), .offset_range_select(ofs), .core_volt_atten_bypass(byp));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic [1:0] r;
      H.xfer(1'b1, a, d, q, r);
   endtask
   task automatic rd(input logic [7:0] a);
      H.xfer(1'b0, a, 8'h00, rq, rr);
   endtask
   task automatic conclude();
      $display("mismatches %0d of %0d checks", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         conclude();
      end
   end
   initial
   begin
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         rd(8'(8'h7c + i));
         chk(rq, 8'h00);
      end
      foreach (rows[i])
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16]);
         chk(rq, rows[i][7:0]);
      end
      rd(8'h90);
      chk({6'h0, rr}, 8'h03);
      mp_drv <= 1'b1;
      for (int c = 0; c < 4; c++)
      begin
         wr(ADDR_PIN_CFG, 8'(c));
         repeat (4) @(posedge mclk);
         chk({6'h0, tach, gp_in}, {6'h0, c == 0, c == 3});
      end
      t_ra <= 8'h60;
      foreach (ot[i])
      begin
         wr(ot[i][19:12], ot[i][11:4]);
         repeat (4) @(posedge mclk);
         chk({7'h0, ot_oe}, {7'h0, ot[i][2]});
         chk({5'h0, ot_out, full, maxp}, {6'h0, ot[i][1:0]});
      end
      gp_lvl <= 1'b1;
      wr(ADDR_PIN_CFG, {6'h00, MPF_GPIO});
      wr(ADDR_FMT_CFG, 8'h04);
      repeat (4) @(posedge mclk);
      chk({6'h0, mp_oe, mp_out}, 8'h02);
      wr(ADDR_FMT_CFG, 8'h0c);
      repeat (4) @(posedge mclk);
      chk({6'h0, mp_oe, mp_out}, 8'h03);
      ot_ext <= 1'b0;
      repeat (4) @(posedge mclk);
      chk({7'h0, tmr}, 8'h01);
      ot_ext <= 1'b1;
      wr(ADDR_LOCK_CTRL, 8'h01);
      wr(ADDR_FMT_CFG, 8'hff);
      rd(ADDR_FMT_CFG);
      chk(rq, 8'h0c);
      wr(ADDR_PIN_CFG, 8'h40);
      rd(ADDR_PIN_CFG);
      chk(rq, 8'h03);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(ADDR_FMT_CFG);
      chk(rq, 8'h00);
      wr(ADDR_FMT_CFG, 8'h02);
      rd(ADDR_FMT_CFG);
      chk(rq, 8'h02);
      conclude();
   end
endmodule

// ===== tb/tmc_host_model.sv
// host model: avalon-mm master issuing byte register accesses
`timescale 1ns/1ps
module tmc_host_model
   import tmc_pkg::*;
(
   // clock
   input wire logic mclk,
   // avalon-mm master
   output logic [ADDR_W-1:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response
);
   // ****************
   // bus access
   // ****************
   initial
   begin
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end
   // word access with all four byte lanes enabled, data in the low byte, at register index, held until waitrequest low
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic [1:0] r);
      @(posedge mclk);
      avs_address <= {a, 2'b00};
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= 4'hf;
      @(posedge mclk);
      while (avs_waitrequest)
         @(posedge mclk);
      q = avs_readdata[7:0];
      r = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= ~{24'h0, d};
   endtask
endmodule

// ===== tb/tmc_regs_properties.sv
// checker: bus timing and config-bit relations of the config block
`timescale 1ns/1ps
module tmc_regs_chk
   import tmc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   // control outputs
   input wire logic fans_full_speed,
   input wire logic fans_max_prog,
   input wire logic temp_format_select,
   input wire logic offset_range_select,
   input wire logic core_volt_atten_bypass
);
   // ****************
   // bus and control-output relations
   // ****************
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic lock_q;
   logic acc;
   logic wfmt;
   logic wpin;
   logic [7:0] ra;
   assign ra = avs_address[ADDR_W-1:2];
   assign acc = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign wfmt = acc && ra == ADDR_FMT_CFG;
   assign wpin = acc && ra == ADDR_PIN_CFG;
   always_ff @(posedge mclk or negedge reset_n)
      if (!reset_n)
         lock_q <= 1'b0;
      else if (acc && ra == ADDR_LOCK_CTRL && avs_writedata[0])
         lock_q <= 1'b1;
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("no answer one cycle after request");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read lanes not zero");
   a_resp_code: assert property (!avs_waitrequest |-> avs_response ==
      ((ra < ADDR_FMT_CFG || ra > ADDR_STATUS) ? 2'h3 : 2'h0)) else $error("bad response");
   a_test_zero: assert property (!avs_waitrequest && avs_read && ra[7:1] == 7'h3f
      |-> avs_readdata[7:0] == 8'h00) else $error("test register not zero");
   a_resv_zero: assert property (!avs_waitrequest && avs_read && ra[7:1] == 7'h3e
      |-> (avs_readdata[7:0] & ~(ra[0] ? PIN_CFG_WMASK : FMT_CFG_WMASK)) == 8'h00)
      else $error("reserved bit reads one");
   a_fmt_copy: assert property (wfmt && !lock_q |-> ##2
      temp_format_select == $past(avs_writedata[FMT_TWOS_BIT], 2)) else $error("format bit");
   a_range_copy: assert property (wfmt && !lock_q |-> ##2
      offset_range_select == $past(avs_writedata[FMT_OFFS_BIT], 2)) else $error("range bit");
   a_byp_copy: assert property (wpin && !lock_q |-> ##2
      core_volt_atten_bypass == $past(avs_writedata[PIN_BYP_BIT], 2)) else $error("bypass bit");
   a_lock_hold: assert property ((wfmt || wpin) && lock_q |-> ##2
      $stable(temp_format_select) && $stable(core_volt_atten_bypass)) else $error("locked write");
   a_fan_excl: assert property (!(fans_full_speed && fans_max_prog))
      else $error("both fan modes active");
endmodule
bind tmc_config_regs tmc_regs_chk u_chk (.mclk(mclk), .reset_n(reset_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .avs_response(avs_response), .fans_full_speed(fans_full_speed),
   .fans_max_prog(fans_max_prog), .temp_format_select(temp_format_select),
   .offset_range_select(offset_range_select), .core_volt_atten_bypass(core_volt_atten_bypass));
